/* common/fei_pkg.sv */
`default_nettype none
package fei_pkg;
  localparam logic [7:0] OFS_PG_LIVE    = 8'h0D;
  localparam logic [7:0] OFS_FLAGS      = 8'h0E;
  localparam logic [7:0] OFS_REPORT_EN  = 8'h0F;
  localparam logic [7:0] OFS_RESTORE    = 8'h11;
  localparam logic [7:0] RESTORE_KEY    = 8'h7F;

  localparam int         NUM_CH         = 4;
  localparam int         NUM_EVT        = 6;
  localparam int         BIT_OVERHEAT   = 5;
  localparam int         BIT_LOW_SUPPLY = 4;

  localparam logic [5:0] FLAGS_RST      = 6'h00;
  localparam logic [5:0] REPORT_EN_RST  = 6'h00;
  localparam logic [3:0] PG_RST         = 4'h0;
  localparam logic [5:0] CLR_ALL        = 6'h3F;
  localparam logic [1:0] RSVD_EVT_RD    = 2'h0;
  localparam logic [3:0] RSVD_PG_RD     = 4'h0;
  localparam logic [7:0] UNMAPPED_RD    = 8'h00;

  localparam logic [6:0] I2C_DEV_ADDR   = 7'h48;
  localparam logic [3:0] I2C_BITS       = 4'h8;
  localparam logic [3:0] I2C_CNT_RST    = 4'h0;
  localparam logic [7:0] BYTE_RST       = 8'h00;

  typedef enum logic [4:0] {
    FEI_I2C_IDLE = 5'h01,
    FEI_I2C_RX   = 5'h02,
    FEI_I2C_ACK  = 5'h04,
    FEI_I2C_TX   = 5'h08,
    FEI_I2C_RACK = 5'h10
  } fei_i2c_st_t;

  typedef enum logic [2:0] {
    FEI_PH_ADDR = 3'h1,
    FEI_PH_PTR  = 3'h2,
    FEI_PH_DATA = 3'h4
  } fei_phase_t;

  typedef struct packed {
    fei_i2c_st_t st;
    fei_phase_t  phase;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        rw;
    logic        scl_p;
    logic        sda_p;
    logic        sda_oe;
    logic        sda_out;
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
  } fei_i2c_state_t;

  typedef struct packed {
    logic [5:0] flags;
    logic [5:0] report_en;
    logic [3:0] pg_prev;
    logic [3:0] pg_live;
    logic       int_b;
  } fei_core_state_t;
endpackage
`default_nettype wire

/* rtl/fei_i2c_slave.sv */
`default_nettype none
module fei_i2c_slave (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  localparam fei_pkg::fei_i2c_state_t RST_S = '{
    st: fei_pkg::FEI_I2C_IDLE, phase: fei_pkg::FEI_PH_ADDR, cnt: fei_pkg::I2C_CNT_RST,
    sh: fei_pkg::BYTE_RST, ptr: fei_pkg::BYTE_RST, rw: 1'b0, scl_p: 1'b1, sda_p: 1'b1,
    sda_oe: 1'b0, sda_out: 1'b0, wr_stb: 1'b0, wr_addr: fei_pkg::BYTE_RST, wr_data: fei_pkg::BYTE_RST};

  fei_pkg::fei_i2c_state_t s_q;
  fei_pkg::fei_i2c_state_t s_d;
  logic                    rise;
  logic                    fall;

  assign rise = scl_in & ~s_q.scl_p;
  assign fall = ~scl_in & s_q.scl_p;

  always_comb begin
    s_d        = s_q;
    s_d.scl_p  = scl_in;
    s_d.sda_p  = sda_in;
    s_d.wr_stb = 1'b0;
    if (scl_in && s_q.scl_p && s_q.sda_p && !sda_in) begin
      // Start or repeated start; pointer survives for combined reads
      s_d.st     = fei_pkg::FEI_I2C_RX;
      s_d.phase  = fei_pkg::FEI_PH_ADDR;
      s_d.cnt    = fei_pkg::I2C_CNT_RST;
      s_d.sda_oe = 1'b0;
    end else if (scl_in && s_q.scl_p && !s_q.sda_p && sda_in) begin
      s_d.st     = fei_pkg::FEI_I2C_IDLE;
      s_d.sda_oe = 1'b0;
    end else begin
      case (s_q.st)
        fei_pkg::FEI_I2C_RX: begin
          if (rise) begin
            s_d.sh  = {s_q.sh[6:0], sda_in};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (fall && s_q.cnt == fei_pkg::I2C_BITS) begin
            s_d.cnt    = fei_pkg::I2C_CNT_RST;
            s_d.st     = fei_pkg::FEI_I2C_ACK;
            s_d.sda_oe = 1'b1;
            case (s_q.phase)
              fei_pkg::FEI_PH_ADDR: begin
                if (s_q.sh[7:1] == fei_pkg::I2C_DEV_ADDR) begin
                  s_d.rw    = s_q.sh[0];
                  s_d.phase = fei_pkg::FEI_PH_PTR;
                end else begin
                  s_d.st     = fei_pkg::FEI_I2C_IDLE;
                  s_d.sda_oe = 1'b0;
                end
              end
              fei_pkg::FEI_PH_PTR: begin
                s_d.ptr   = s_q.sh;
                s_d.phase = fei_pkg::FEI_PH_DATA;
              end
              default: begin
                s_d.wr_stb  = 1'b1;
                s_d.wr_addr = s_q.ptr;
                s_d.wr_data = s_q.sh;
                s_d.ptr     = s_q.ptr + 8'h01;
              end
            endcase
          end
        end
        fei_pkg::FEI_I2C_ACK: begin
          if (fall) begin
            if (s_q.rw) begin
              s_d.st     = fei_pkg::FEI_I2C_TX;
              s_d.sh     = rd_data;
              s_d.sda_oe = ~rd_data[7];
            end else begin
              s_d.st     = fei_pkg::FEI_I2C_RX;
              s_d.sda_oe = 1'b0;
            end
          end
        end
        fei_pkg::FEI_I2C_TX: begin
          if (rise) begin
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (fall) begin
            if (s_q.cnt == fei_pkg::I2C_BITS) begin
              s_d.st     = fei_pkg::FEI_I2C_RACK;
              s_d.sda_oe = 1'b0;
              s_d.ptr    = s_q.ptr + 8'h01;
            end else begin
              s_d.sh     = {s_q.sh[6:0], 1'b0};
              s_d.sda_oe = ~s_q.sh[6];
            end
          end
        end
        fei_pkg::FEI_I2C_RACK: begin
          if (rise && sda_in) begin
            s_d.st = fei_pkg::FEI_I2C_IDLE;
          end else if (fall) begin
            s_d.st     = fei_pkg::FEI_I2C_TX;
            s_d.cnt    = fei_pkg::I2C_CNT_RST;
            s_d.sh     = rd_data;
            s_d.sda_oe = ~rd_data[7];
          end
        end
        default: begin
          s_d.st = fei_pkg::FEI_I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_out = s_q.sda_out;
  assign sda_oe  = s_q.sda_oe;
  assign wr_stb  = s_q.wr_stb;
  assign wr_addr = s_q.wr_addr;
  assign wr_data = s_q.wr_data;
  assign rd_addr = s_q.ptr;
endmodule
`default_nettype wire

/* rtl/fei_fault_irq.sv */
`default_nettype none
module fei_fault_irq (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       overheat_warn,
  input  wire logic       low_supply_warn,
  input  wire logic [3:0] pg_level,
  input  wire logic [3:0] channel_enable_pins,
  input  wire logic       pg_event_blank,
  output logic            fault_req_b
);
  localparam fei_pkg::fei_core_state_t RST_S = '{
    flags: fei_pkg::FLAGS_RST, report_en: fei_pkg::REPORT_EN_RST,
    pg_prev: fei_pkg::PG_RST, pg_live: fei_pkg::PG_RST, int_b: 1'b1};

  fei_pkg::fei_core_state_t s_q;
  fei_pkg::fei_core_state_t s_d;
  logic                     wr_stb;
  logic [7:0]               wr_addr;
  logic [7:0]               wr_data;
  logic [7:0]               rd_addr;
  logic [7:0]               rd_data;
  logic                     wr_flags;
  logic                     wr_report_en;
  logic                     restore;
  logic                     all_off;
  logic [3:0]               pg_fail;
  logic [5:0]               events;
  logic [5:0]               clr;

  fei_i2c_slave u_i2c (
    .clk     (clk),
    .rst_b   (rst_b),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  assign wr_flags     = wr_stb && (wr_addr == fei_pkg::OFS_FLAGS);
  assign wr_report_en = wr_stb && (wr_addr == fei_pkg::OFS_REPORT_EN);
  assign restore      = wr_stb && (wr_addr == fei_pkg::OFS_RESTORE) && (wr_data == fei_pkg::RESTORE_KEY);
  assign all_off      = (channel_enable_pins == fei_pkg::PG_RST);

  // Falling power-good only counts on an enabled, unblanked channel
  genvar g;
  generate
    for (g = 0; g < fei_pkg::NUM_CH; g++) begin : g_pg
      assign pg_fail[g] = s_q.pg_prev[g] & ~pg_level[g] & channel_enable_pins[g] & ~pg_event_blank;
    end
  endgenerate

  assign events = {overheat_warn, low_supply_warn, pg_fail};

  always_comb begin
    s_d = s_q;
    if (restore || all_off) begin
      clr = fei_pkg::CLR_ALL;
    end else if (wr_flags) begin
      clr = wr_data[5:0];
    end else begin
      clr = fei_pkg::FLAGS_RST;
    end
    // Set beats clear so an event in the clearing cycle survives
    s_d.flags = (s_q.flags & ~clr) | events;
    if (restore) begin
      s_d.report_en = fei_pkg::REPORT_EN_RST;
    end else if (wr_report_en) begin
      s_d.report_en = wr_data[5:0];
    end
    s_d.pg_prev = pg_level;
    s_d.pg_live = pg_level;
    // Built from next state so the pin tracks the flags with no extra lag
    s_d.int_b = ~|(s_d.flags & s_d.report_en);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    if (rd_addr == fei_pkg::OFS_PG_LIVE) begin
      rd_data = {fei_pkg::RSVD_PG_RD, s_q.pg_live};
    end else if (rd_addr == fei_pkg::OFS_FLAGS) begin
      rd_data = {fei_pkg::RSVD_EVT_RD, s_q.flags};
    end else if (rd_addr == fei_pkg::OFS_REPORT_EN) begin
      rd_data = {fei_pkg::RSVD_EVT_RD, s_q.report_en};
    end else begin
      rd_data = fei_pkg::UNMAPPED_RD;
    end
  end

  assign fault_req_b = s_q.int_b;

  property p_pin_low;
    @(posedge clk) disable iff (!rst_b)
    (|(s_q.flags & s_q.report_en)) |-> !fault_req_b;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("fault pin high with enabled flag");

  property p_pin_release;
    @(posedge clk) disable iff (!rst_b)
    !(|(s_q.flags & s_q.report_en)) |-> fault_req_b;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("fault pin low with no enabled flag");

  property p_masked_quiet;
    @(posedge clk) disable iff (!rst_b)
    (s_q.report_en == fei_pkg::REPORT_EN_RST) |-> fault_req_b;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("fault pin low while all masked");

  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
    (!wr_flags && !all_off && !restore) |=> ((s_q.flags & $past(s_q.flags)) == $past(s_q.flags));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_w1c;
    @(posedge clk) disable iff (!rst_b)
    (wr_flags && events == fei_pkg::FLAGS_RST) |=> ((s_q.flags & $past(wr_data[5:0])) == fei_pkg::FLAGS_RST);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one did not clear flag");

  property p_all_off;
    @(posedge clk) disable iff (!rst_b)
    (all_off && !overheat_warn && !low_supply_warn) |=> (s_q.flags == fei_pkg::FLAGS_RST);
  endproperty
  a_all_off: assert property (p_all_off) else $error("flags kept with all channels off");

  property p_overheat;
    @(posedge clk) disable iff (!rst_b)
    overheat_warn |=> s_q.flags[fei_pkg::BIT_OVERHEAT] ##1
      (s_q.flags[fei_pkg::BIT_OVERHEAT] || $past(wr_flags || all_off || restore));
  endproperty
  a_overheat: assert property (p_overheat) else $error("overheat flag not latched");

  property p_low_supply;
    @(posedge clk) disable iff (!rst_b)
    low_supply_warn |=> s_q.flags[fei_pkg::BIT_LOW_SUPPLY];
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("low supply flag not latched");

  property p_pg_fail;
    @(posedge clk) disable iff (!rst_b)
    (|pg_fail) |=> ((s_q.flags[3:0] & $past(pg_fail)) == $past(pg_fail));
  endproperty
  a_pg_fail: assert property (p_pg_fail) else $error("power-good failure not latched");

  property p_blank;
    @(posedge clk) disable iff (!rst_b)
    pg_event_blank |=> ((s_q.flags[3:0] & ~$past(s_q.flags[3:0])) == fei_pkg::PG_RST);
  endproperty
  a_blank: assert property (p_blank) else $error("power-good flag set while blanked");

  property p_en_write;
    @(posedge clk) disable iff (!rst_b)
    (wr_report_en && !restore) |=> (s_q.report_en == $past(wr_data[5:0]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("report enable not written");

  property p_restore;
    @(posedge clk) disable iff (!rst_b)
    (restore && events == fei_pkg::FLAGS_RST) |=> (s_q.report_en == fei_pkg::REPORT_EN_RST)
      && (s_q.flags == fei_pkg::FLAGS_RST) && fault_req_b;
  endproperty
  a_restore: assert property (p_restore) else $error("restore command left state");

  property p_pg_live;
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> (s_q.pg_live == $past(pg_level));
  endproperty
  a_pg_live: assert property (p_pg_live) else $error("live power-good readback stale");

  // Reset is synchronous, so state is checked one edge after a low sample
  property p_reset_state;
    @(posedge clk)
    !rst_b |=> (s_q.flags == fei_pkg::FLAGS_RST) && (s_q.report_en == fei_pkg::REPORT_EN_RST)
      && fault_req_b;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_no_spurious;
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> ((s_q.flags & ~$past(s_q.flags) & ~$past(events)) == fei_pkg::FLAGS_RST);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set with no event");

  property p_low_supply_hold;
    @(posedge clk) disable iff (!rst_b)
    low_supply_warn |=> s_q.flags[fei_pkg::BIT_LOW_SUPPLY] ##1
      (s_q.flags[fei_pkg::BIT_LOW_SUPPLY] || $past(wr_flags || all_off || restore));
  endproperty
  a_low_supply_hold: assert property (p_low_supply_hold) else $error("low supply flag lost");

  property p_hold_low;
    @(posedge clk) disable iff (!rst_b)
    (!fault_req_b && !wr_stb && !all_off) |=> !fault_req_b;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("fault pin released with no clear");

  property p_pin_follow;
    @(posedge clk) disable iff (!rst_b)
    $changed(fault_req_b) |-> ($changed(s_q.flags) || $changed(s_q.report_en));
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("fault pin moved on its own");

  property p_clear_release;
    @(posedge clk) disable iff (!rst_b)
    (wr_flags && ((s_q.flags & s_q.report_en & ~wr_data[5:0]) == fei_pkg::FLAGS_RST)
      && ((events & s_q.report_en) == fei_pkg::FLAGS_RST)) |=> fault_req_b;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("fault pin held after clear");

  property p_en_remove;
    @(posedge clk) disable iff (!rst_b)
    (wr_report_en && (((s_q.flags | events) & wr_data[5:0]) == fei_pkg::FLAGS_RST)) |=> fault_req_b;
  endproperty
  a_en_remove: assert property (p_en_remove) else $error("fault pin held by blocked event");

  property p_all_off_pin;
    @(posedge clk) disable iff (!rst_b)
    (all_off && !overheat_warn && !low_supply_warn) |=> fault_req_b;
  endproperty
  a_all_off_pin: assert property (p_all_off_pin) else $error("fault pin low with channels off");

  property p_en_hold;
    @(posedge clk) disable iff (!rst_b)
    (!wr_report_en && !restore) |=> $stable(s_q.report_en);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("report enable changed unwritten");

  // Any other value at the restore address must leave the enables alone
  property p_restore_key;
    @(posedge clk) disable iff (!rst_b)
    (wr_stb && (wr_addr == fei_pkg::OFS_RESTORE) && (wr_data != fei_pkg::RESTORE_KEY))
      |=> $stable(s_q.report_en);
  endproperty
  a_restore_key: assert property (p_restore_key) else $error("restore taken on wrong key");

  property p_pg_ro;
    @(posedge clk) disable iff (!rst_b)
    (wr_stb && (wr_addr == fei_pkg::OFS_PG_LIVE)) |=> $stable(s_q.report_en);
  endproperty
  a_pg_ro: assert property (p_pg_ro) else $error("write to live power-good had effect");

  property p_wr_pulse;
    @(posedge clk) disable iff (!rst_b)
    wr_stb |=> !wr_stb;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

  // Read path is combinational from state, so decode is checked in the same cycle
  property p_rd_pg;
    @(posedge clk) disable iff (!rst_b)
    (rd_addr == fei_pkg::OFS_PG_LIVE) |-> (rd_data == {fei_pkg::RSVD_PG_RD, $past(pg_level)});
  endproperty
  a_rd_pg: assert property (p_rd_pg) else $error("live power-good readback wrong");

  property p_rd_flags;
    @(posedge clk) disable iff (!rst_b)
    (rd_addr == fei_pkg::OFS_FLAGS) |-> (rd_data == {fei_pkg::RSVD_EVT_RD, s_q.flags});
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag readback wrong");

  property p_rd_en;
    @(posedge clk) disable iff (!rst_b)
    (rd_addr == fei_pkg::OFS_REPORT_EN) |-> (rd_data == {fei_pkg::RSVD_EVT_RD, s_q.report_en});
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");

  property p_rd_unmapped;
    @(posedge clk) disable iff (!rst_b)
    ((rd_addr != fei_pkg::OFS_PG_LIVE) && (rd_addr != fei_pkg::OFS_FLAGS) && (rd_addr != fei_pkg::OFS_REPORT_EN))
      |-> (rd_data == fei_pkg::UNMAPPED_RD);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped or write-only read not zero");

  // A disabled channel is shut down, so its power-good drop is no fault
  generate
    for (g = 0; g < fei_pkg::NUM_CH; g++) begin : g_pg_chk
      property p_pg_need_en;
        @(posedge clk) disable iff (!rst_b)
        !channel_enable_pins[g] |=> !(s_q.flags[g] && !$past(s_q.flags[g]));
      endproperty
      a_pg_need_en: assert property (p_pg_need_en) else $error("power-good flag on disabled channel");
    end
  endgenerate
endmodule
`default_nettype wire

/* verification/fei_i2c_host.sv */
`default_nettype none
module fei_i2c_host (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Four clk per phase, twice the minimum, so sampling skew never bites
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // Also serves as repeated start: SDA released while SCL low first
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // SDA only moves while SCL is low
  task automatic clk_bit(input logic low, output logic seen);
    sda_low = low;
    half();
    scl = 1'b1;
    half();
    seen = sda_line;
    scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = ~s;
  endtask

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, b[i]);
    clk_bit(~last, s);
  endtask

  task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1;
    logic k2;
    logic k3;
    start();
    send(dev, k1);
    send(a, k2);
    send(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    send({fei_pkg::I2C_DEV_ADDR, 1'b0}, k);
    send(a, k);
    start();
    send({fei_pkg::I2C_DEV_ADDR, 1'b1}, k);
    recv(1'b1, d);
    stop();
  endtask
endmodule
`default_nettype wire

/* verification/fei_fault_irq_bench.sv */
`default_nettype none
module fei_fault_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [5:0] evt;
    logic [5:0] en;
    logic [7:0] flags;
    logic       int_b;
  } fei_row_t;

  localparam logic [7:0] DEV_W = {fei_pkg::I2C_DEV_ADDR, 1'b0};
  localparam fei_row_t ROWS [6] = '{
    '{6'h20, 6'h20, 8'h20, 1'b0}, '{6'h10, 6'h10, 8'h10, 1'b0}, '{6'h05, 6'h04, 8'h05, 1'b0},
    '{6'h0A, 6'h05, 8'h0A, 1'b1}, '{6'h20, 6'h1F, 8'h20, 1'b1}, '{6'h18, 6'h08, 8'h18, 1'b0}};

  logic       clk       = 1'b0;
  logic       rst_b     = 1'b0;
  logic       ovh       = 1'b0;
  logic       lvs       = 1'b0;
  logic [3:0] pg_level  = 4'hF;
  logic [3:0] en_pins   = 4'hF;
  logic       blank     = 1'b0;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic       fault_req_b;
  logic       ok;
  wire logic  sda_line;
  int         n_errors  = 0;
  int         n_tests   = 0;
  int         cycles    = 0;

  // Open-drain wire with pull-up
  assign sda_line = ~(sda_low | sda_oe);

  always #2.5 clk = ~clk;

  fei_i2c_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  fei_fault_irq uut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .overheat_warn(ovh), .low_supply_warn(lvs), .pg_level(pg_level), .channel_enable_pins(en_pins),
    .pg_event_blank(blank), .fault_req_b(fault_req_b));

  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr(DEV_W, a, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask

  // Condition drops again before software looks at it
  task automatic fire(input logic [5:0] e);
    @(negedge clk);
    ovh = e[5];
    lvs = e[4];
    pg_level = ~e[3:0];
    @(negedge clk);
    ovh = 1'b0;
    lvs = 1'b0;
    pg_level = 4'hF;
    repeat (3) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    foreach (ROWS[i]) begin
      wreg(fei_pkg::OFS_REPORT_EN, {2'h0, ROWS[i].en});
      fire(ROWS[i].evt);
      check({7'h00, fault_req_b}, {7'h00, ROWS[i].int_b});
      rreg(fei_pkg::OFS_FLAGS, ROWS[i].flags);
      rreg(fei_pkg::OFS_REPORT_EN, {2'h0, ROWS[i].en});
      wreg(fei_pkg::OFS_FLAGS, 8'h3F);
      check({7'h00, fault_req_b}, 8'h01);
      rreg(fei_pkg::OFS_FLAGS, 8'h00);
    end
    fire(6'h30);
    wreg(fei_pkg::OFS_FLAGS, 8'h10);
    rreg(fei_pkg::OFS_FLAGS, 8'h20);
    en_pins = 4'h0;
    repeat (2) @(negedge clk);
    en_pins = 4'hF;
    rreg(fei_pkg::OFS_FLAGS, 8'h00);
    blank = 1'b1;
    fire(6'h0F);
    pg_level = 4'h6;
    rreg(fei_pkg::OFS_PG_LIVE, 8'h06);
    wreg(fei_pkg::OFS_PG_LIVE, 8'hFF);
    rreg(fei_pkg::OFS_PG_LIVE, 8'h06);
    pg_level = 4'hF;
    @(negedge clk);
    blank = 1'b0;
    rreg(fei_pkg::OFS_FLAGS, 8'h00);
    wreg(fei_pkg::OFS_REPORT_EN, 8'h3F);
    fire(6'h20);
    check({7'h00, fault_req_b}, 8'h00);
    wreg(fei_pkg::OFS_RESTORE, 8'h7E);
    rreg(fei_pkg::OFS_REPORT_EN, 8'h3F);
    wreg(fei_pkg::OFS_RESTORE, fei_pkg::RESTORE_KEY);
    check({7'h00, fault_req_b}, 8'h01);
    rreg(fei_pkg::OFS_REPORT_EN, 8'h00);
    rreg(fei_pkg::OFS_FLAGS, 8'h00);
    host.wr(8'hA0, fei_pkg::OFS_REPORT_EN, 8'h3F, ok);
    check({7'h00, ok}, 8'h00);
    rreg(fei_pkg::OFS_REPORT_EN, 8'h00);
    rreg(8'h12, fei_pkg::UNMAPPED_RD);
    // Burst write then burst read, so the pointer steps from flags to enables
    host.start();
    host.send(DEV_W, ok);
    host.send(fei_pkg::OFS_FLAGS, ok);
    host.send(8'h00, ok);
    host.send(8'h21, ok);
    host.stop();
    check({7'h00, ok}, 8'h01);
    host.start();
    host.send(DEV_W, ok);
    host.send(fei_pkg::OFS_FLAGS, ok);
    host.start();
    host.send({fei_pkg::I2C_DEV_ADDR, 1'b1}, ok);
    host.recv(1'b0, rd_a);
    host.recv(1'b1, rd_b);
    host.stop();
    check(rd_a, 8'h00);
    check(rd_b, 8'h21);
    check({7'h00, sda_out}, 8'h00);
    wreg(fei_pkg::OFS_REPORT_EN, 8'h3F);
    fire(6'h10);
    check({7'h00, fault_req_b}, 8'h00);
    rst_b = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check({7'h00, fault_req_b}, 8'h01);
    rreg(fei_pkg::OFS_REPORT_EN, 8'h00);
    rreg(fei_pkg::OFS_FLAGS, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
